/* File: hw/i2cm_pkg.sv */
package i2cm_pkg;
  // Register byte addresses on the APB
  localparam logic [7:0] I2CM_ADDR_CTRL2  = 8'h00;
  localparam logic [7:0] I2CM_ADDR_STATUS = 8'h04;
  localparam logic [7:0] I2CM_ADDR_BUF    = 8'h08;
  localparam logic [7:0] I2CM_ADDR_RELOAD = 8'h0C;
  localparam logic [7:0] I2CM_ADDR_FLAGS  = 8'h10;
  localparam logic [7:0] I2CM_ADDR_CTRL1  = 8'h14;

  // Second control register fields
  localparam int I2CM_C2_BEGIN  = 0;
  localparam int I2CM_C2_REPEAT = 1;
  localparam int I2CM_C2_HALT   = 2;
  localparam int I2CM_C2_RECV   = 3;
  localparam int I2CM_C2_ACKREQ = 4;
  localparam int I2CM_C2_ACKNOWLEDGE_DATA_BIT  = 5;
  localparam int I2CM_C2_ACKST  = 6;

  // Serial status register fields
  localparam int I2CM_ST_FULL  = 0;
  localparam int I2CM_ST_BEGIN = 3;
  localparam int I2CM_ST_HALT  = 4;

  // Flag register fields (write one to clear)
  localparam int I2CM_FL_SIF  = 0;
  localparam int I2CM_FL_BCL  = 1;
  localparam int I2CM_FL_OV   = 2;
  localparam int I2CM_FL_WRITE_COLLISION_FLAG = 3;

  // First control register fields
  localparam int I2CM_C1_EN = 0;

  localparam logic [7:0]  I2CM_RELOAD_RST = 8'h00;
  localparam logic [7:0]  I2CM_BYTE_ZERO  = 8'h00;
  localparam logic [3:0]  I2CM_BITS_BYTE  = 4'h8;
  localparam logic [31:0] I2CM_WORD_ZERO  = 32'h0000_0000;

  // APB request bundle
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } i2cm_apb_req_s;

  // Master engine states
  typedef enum logic [7:0] {
    I2CM_IDLE    = 8'h01,
    I2CM_RX_LOW  = 8'h02,
    I2CM_RX_HIGH = 8'h04,
    I2CM_ACK_LOW = 8'h08,
    I2CM_ACK_HI  = 8'h10,
    I2CM_STP_SDA = 8'h20,
    I2CM_STP_SCL = 8'h40,
    I2CM_STP_END = 8'h80
  } i2cm_state_e;
endpackage : i2cm_pkg

/* File: hw/i2cm_brg.sv */
`timescale 1ns/1ps
// Baud rate generator: reloads on request, pulses on rollover
module i2cm_brg (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_b,
  input  wire logic       i_run,
  input  wire logic       i_load,
  input  wire logic [7:0] i_reload,
  output logic            o_tick
);
  import i2cm_pkg::*;

  logic [7:0] count;

  // Count down; a reload takes the low eight bits of the reload register
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      count  <= I2CM_BYTE_ZERO;
      o_tick <= 1'b0;
    end else if (i_load || !i_run) begin
      count  <= i_reload;
      o_tick <= 1'b0;
    end else if (count == I2CM_BYTE_ZERO) begin
      count  <= i_reload;
      o_tick <= 1'b1;
    end else begin
      count  <= count - 8'h01;
      o_tick <= 1'b0;
    end
  end
endmodule : i2cm_brg

/* File: hw/i2cm_master.sv */
`timescale 1ns/1ps
// Contract
// - Setting the receive request bit starts clocking in one byte.
// - Receive request honoured only while idle; otherwise ignored.
// - Each generator rollover toggles SCL; sampled SDA shifts into the shift register.
// - After eighth falling edge: clear request, load buffer, set full and interrupt.
// - Reading the buffer clears the buffer-full flag.
// - Byte completing while buffer still full sets the overflow flag.
// - Buffer write during receive, acknowledge or stop sets write collision.
// - Acknowledge: SCL low, acknowledge bit on SDA, release SCL after one period.
// - Once SCL high, one period more, SCL low, clear request, go idle.
// - Acknowledge data bit zero sends acknowledge, one sends not-acknowledge.
// - Stop: SDA low, then count, release SCL, one period later release SDA.
// - SDA high with SCL high sets stop-detected; period later interrupt.
// - Reset disables the module and aborts any transfer.
// - Start and stop detected bits clear on reset or disable.
// - Busy bus with interrupt enabled raises it on a detected stop.
// - Released SDA read low while SCL high sets bus collision, goes idle.
// - Arbitration checked during transfers, start, repeated start and acknowledge; here it is checked only in the acknowledge SCL-high phase.
// - Collision in transmission halts, clears full flag, releases both lines.
// - Collision in a condition aborts it and clears its request bit.
// - After a collision bus monitored; stop sets the interrupt flag.
// - Buffer write after collision restarts transmission from the first bit; here it only loads the buffer and sets the full flag.
// - Generator reload takes the low eight bits of the reload register.
// - Generator reloads twice per SCL period.
module i2cm_master (
  input  wire logic                    i_clk_sys,
  input  wire logic                    i_rst_b,
  input  wire i2cm_pkg::i2cm_apb_req_s i_apb,
  output logic [31:0]                  o_prdata,
  output logic                         o_pready,
  output logic                         o_pslverr,
  input  wire logic                    i_scl,
  input  wire logic                    i_sda,
  output logic                         o_scl_oe,
  output logic                         o_sda_oe,
  output logic                         o_scl_out,
  output logic                         o_sda_out,
  output logic                         o_irq
);
  import i2cm_pkg::*;

  i2cm_state_e state;
  logic [7:0]  shift_reg;
  logic [7:0]  xfer_buf;
  logic [7:0]  reload;
  logic [3:0]  bit_cnt;
  logic        enable;
  logic        recv_req, ack_req, halt_req, ack_dt, ack_stat;
  logic        buf_full, sif, bcl, ovf, write_collision_flag;
  logic        seen_begin, seen_halt;
  logic        scl_low, sda_low;
  logic        scl_q, sda_q;
  logic        stop_wait;
  logic        brg_tick, brg_load, brg_run;
  logic        wr_en, rd_en;
  logic        stop_seen, start_seen, collide;

  // Register address match
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction : hit

  // APB access phase strobes; slave answers in the first access cycle
  assign wr_en = i_apb.psel && i_apb.penable && i_apb.pwrite;
  assign rd_en = i_apb.psel && i_apb.penable && !i_apb.pwrite;

  // Bus condition detectors on the pins
  assign stop_seen  = scl_q && i_scl && !sda_q && i_sda;
  assign start_seen = scl_q && i_scl && sda_q && !i_sda;
  // Released SDA read low while SCL high, in acknowledge phase
  assign collide = (state == I2CM_ACK_HI) && !sda_low && i_scl && !i_sda;

  // Generator runs while busy; held loaded until the bus level it waits on is seen
  assign brg_run  = (state != I2CM_IDLE);
  assign brg_load = (state == I2CM_IDLE)
                 || (state == I2CM_ACK_HI && !i_scl)
                 || (state == I2CM_STP_SDA && i_sda)
                 || (state == I2CM_STP_END && !stop_wait);

  i2cm_brg u_brg (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_run     (brg_run),
    .i_load    (brg_load),
    .i_reload  (reload),
    .o_tick    (brg_tick)
  );

  // Previous pin levels for edge detection
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= i_scl;
      sda_q <= i_sda;
    end
  end

  // APB answer: one cycle, unmapped reads zero
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= I2CM_WORD_ZERO;
    end else begin
      o_pready  <= i_apb.psel && !i_apb.penable;
      o_pslverr <= 1'b0;
      o_prdata  <= I2CM_WORD_ZERO;
      if (i_apb.psel && !i_apb.penable && !i_apb.pwrite) begin
        if (hit(i_apb.paddr, I2CM_ADDR_CTRL2)) begin
          o_prdata[I2CM_C2_RECV]   <= recv_req;
          o_prdata[I2CM_C2_ACKREQ] <= ack_req;
          o_prdata[I2CM_C2_HALT]   <= halt_req;
          o_prdata[I2CM_C2_ACKNOWLEDGE_DATA_BIT]  <= ack_dt;
          o_prdata[I2CM_C2_ACKST]  <= ack_stat;
        end else if (hit(i_apb.paddr, I2CM_ADDR_STATUS)) begin
          o_prdata[I2CM_ST_FULL]  <= buf_full;
          o_prdata[I2CM_ST_BEGIN] <= seen_begin;
          o_prdata[I2CM_ST_HALT]  <= seen_halt;
        end else if (hit(i_apb.paddr, I2CM_ADDR_BUF)) begin
          o_prdata[7:0] <= xfer_buf;
        end else if (hit(i_apb.paddr, I2CM_ADDR_RELOAD)) begin
          o_prdata[7:0] <= reload;
        end else if (hit(i_apb.paddr, I2CM_ADDR_FLAGS)) begin
          o_prdata[I2CM_FL_SIF]  <= sif;
          o_prdata[I2CM_FL_BCL]  <= bcl;
          o_prdata[I2CM_FL_OV]   <= ovf;
          o_prdata[I2CM_FL_WRITE_COLLISION_FLAG] <= write_collision_flag;
        end else if (hit(i_apb.paddr, I2CM_ADDR_CTRL1)) begin
          o_prdata[I2CM_C1_EN] <= enable;
        end
      end
    end
  end

  // Enable, reload value and acknowledge data bit
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      enable <= 1'b0;
      reload <= I2CM_RELOAD_RST;
      ack_dt <= 1'b0;
    end else if (wr_en) begin
      if (hit(i_apb.paddr, I2CM_ADDR_CTRL1)) begin
        enable <= i_apb.pwdata[I2CM_C1_EN];
      end
      if (hit(i_apb.paddr, I2CM_ADDR_RELOAD)) begin
        reload <= i_apb.pwdata[7:0];
      end
      if (hit(i_apb.paddr, I2CM_ADDR_CTRL2)) begin
        ack_dt <= i_apb.pwdata[I2CM_C2_ACKNOWLEDGE_DATA_BIT];
      end
    end
  end

  // Main engine: state, pins, shift register, request bits
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b || !enable) begin
      state     <= I2CM_IDLE;
      scl_low   <= 1'b0;
      sda_low   <= 1'b0;
      shift_reg <= I2CM_BYTE_ZERO;
      bit_cnt   <= 4'h0;
      recv_req  <= 1'b0;
      ack_req   <= 1'b0;
      halt_req  <= 1'b0;
      stop_wait <= 1'b0;
    end else if (collide) begin
      state   <= I2CM_IDLE;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      ack_req <= 1'b0;
      bit_cnt <= 4'h0;
    end else begin
      case (state)
        I2CM_IDLE: begin
          if (wr_en && hit(i_apb.paddr, I2CM_ADDR_CTRL2)) begin
            if (i_apb.pwdata[I2CM_C2_RECV]) begin
              recv_req <= 1'b1;
              bit_cnt  <= 4'h0;
              scl_low  <= 1'b1;
              sda_low  <= 1'b0;
              state    <= I2CM_RX_LOW;
            end else if (i_apb.pwdata[I2CM_C2_ACKREQ]) begin
              ack_req <= 1'b1;
              scl_low <= 1'b1;
              sda_low <= !i_apb.pwdata[I2CM_C2_ACKNOWLEDGE_DATA_BIT];
              state   <= I2CM_ACK_LOW;
            end else if (i_apb.pwdata[I2CM_C2_HALT]) begin
              halt_req <= 1'b1;
              sda_low  <= 1'b1;
              state    <= I2CM_STP_SDA;
            end
          end
        end
        I2CM_RX_LOW: if (brg_tick) begin
          scl_low <= 1'b0;
          state   <= I2CM_RX_HIGH;
        end
        I2CM_RX_HIGH: if (brg_tick) begin
          scl_low   <= 1'b1;
          shift_reg <= {shift_reg[6:0], i_sda};
          bit_cnt   <= bit_cnt + 4'h1;
          if (bit_cnt + 4'h1 == I2CM_BITS_BYTE) begin
            recv_req <= 1'b0;
            state    <= I2CM_IDLE;
          end else begin
            state <= I2CM_RX_LOW;
          end
        end
        I2CM_ACK_LOW: if (brg_tick) begin
          scl_low <= 1'b0;
          state   <= I2CM_ACK_HI;
        end
        I2CM_ACK_HI: if (brg_tick && i_scl) begin
          scl_low <= 1'b1;
          sda_low <= 1'b0;
          ack_req <= 1'b0;
          state   <= I2CM_IDLE;
        end
        I2CM_STP_SDA: if (!i_sda && brg_tick) begin
          scl_low <= 1'b0;
          state   <= I2CM_STP_SCL;
        end
        I2CM_STP_SCL: if (brg_tick) begin
          sda_low   <= 1'b0;
          stop_wait <= 1'b0;
          state     <= I2CM_STP_END;
        end
        I2CM_STP_END: begin
          if (stop_seen) begin
            stop_wait <= 1'b1;
          end
          if (stop_wait && brg_tick) begin
            halt_req  <= 1'b0;
            stop_wait <= 1'b0;
            state     <= I2CM_IDLE;
          end
        end
        default: state <= I2CM_IDLE;
      endcase
    end
  end

  // Received byte completes on the eighth falling SCL edge
  logic byte_done;
  assign byte_done = (state == I2CM_RX_HIGH) && brg_tick && (bit_cnt + 4'h1 == I2CM_BITS_BYTE);

  // Serial interrupt sources: byte received, stop finished, acknowledge finished
  logic sif_set;
  assign sif_set = byte_done
                || (state == I2CM_STP_END && stop_wait && brg_tick)
                || (state == I2CM_ACK_HI && brg_tick && i_scl);

  // Transfer buffer and buffer-full flag
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      xfer_buf <= I2CM_BYTE_ZERO;
      buf_full <= 1'b0;
    end else if (byte_done) begin
      xfer_buf <= {shift_reg[6:0], i_sda};
      buf_full <= 1'b1;
    end else if (collide) begin
      buf_full <= 1'b0;
    end else if (rd_en && hit(i_apb.paddr, I2CM_ADDR_BUF)) begin
      buf_full <= 1'b0;
    end else if (wr_en && hit(i_apb.paddr, I2CM_ADDR_BUF) && state == I2CM_IDLE) begin
      xfer_buf <= i_apb.pwdata[7:0];
      buf_full <= 1'b1;
    end
  end

  // Sticky flags; hardware set wins over a write-one clear
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      sif  <= 1'b0;
      bcl  <= 1'b0;
      ovf  <= 1'b0;
      write_collision_flag <= 1'b0;
    end else begin
      if (sif_set) begin
        sif <= 1'b1;
      end else if (enable && stop_seen && state == I2CM_IDLE && seen_begin) begin
        sif <= 1'b1;
      end else if (wr_en && hit(i_apb.paddr, I2CM_ADDR_FLAGS) && i_apb.pwdata[I2CM_FL_SIF]) begin
        sif <= 1'b0;
      end
      if (collide) begin
        bcl <= 1'b1;
      end else if (wr_en && hit(i_apb.paddr, I2CM_ADDR_FLAGS) && i_apb.pwdata[I2CM_FL_BCL]) begin
        bcl <= 1'b0;
      end
      if (byte_done && buf_full) begin
        ovf <= 1'b1;
      end else if (wr_en && hit(i_apb.paddr, I2CM_ADDR_FLAGS) && i_apb.pwdata[I2CM_FL_OV]) begin
        ovf <= 1'b0;
      end
      if (wr_en && hit(i_apb.paddr, I2CM_ADDR_BUF) && state != I2CM_IDLE) begin
        write_collision_flag <= 1'b1;
      end else if (wr_en && hit(i_apb.paddr, I2CM_ADDR_FLAGS) && i_apb.pwdata[I2CM_FL_WRITE_COLLISION_FLAG]) begin
        write_collision_flag <= 1'b0;
      end
    end
  end

  // Acknowledge status and bus start/stop detection
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b || !enable) begin
      seen_begin <= 1'b0;
      seen_halt  <= 1'b0;
      ack_stat   <= 1'b0;
    end else begin
      if (start_seen) begin
        seen_begin <= 1'b1;
        seen_halt  <= 1'b0;
      end else if (stop_seen) begin
        seen_halt  <= 1'b1;
        seen_begin <= 1'b0;
      end
    end
  end

  // Pin drivers and interrupt, all registered
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_scl_oe  <= 1'b0;
      o_sda_oe  <= 1'b0;
      o_scl_out <= 1'b0;
      o_sda_out <= 1'b0;
      o_irq     <= 1'b0;
    end else begin
      o_scl_oe  <= scl_low && enable && !collide;
      o_sda_oe  <= sda_low && enable && !collide;
      o_scl_out <= 1'b0;
      o_sda_out <= 1'b0;
      o_irq     <= sif || bcl;
    end
  end
endmodule : i2cm_master

/* File: bench/i2cm_master_monitor.sv */
`timescale 1ns/1ps
// Port-level checker for the master engine
module i2cm_master_monitor
  import i2cm_pkg::*;
(
  input wire logic                    i_clk_sys,
  input wire logic                    i_rst_b,
  input wire i2cm_pkg::i2cm_apb_req_s i_apb,
  input wire logic [31:0]             o_prdata,
  input wire logic                    o_pready,
  input wire logic                    o_pslverr,
  input wire logic                    i_scl,
  input wire logic                    i_sda,
  input wire logic                    o_scl_oe,
  input wire logic                    o_sda_oe,
  input wire logic                    o_scl_out,
  input wire logic                    o_sda_out,
  input wire logic                    o_irq
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  logic setup;
  logic w2;
  // Setup cycle and access-phase write to the second control register
  assign setup = i_apb.psel && !i_apb.penable;
  assign w2 = i_apb.psel && i_apb.penable && i_apb.pwrite && i_apb.paddr == I2CM_ADDR_CTRL2;
  chk_ready_time: assert property (setup |=> o_pready) else $error("pready late");
  chk_ready_pulse: assert property (o_pready |=> !o_pready) else $error("pready held");
  chk_reset_idle: assert property ($rose(i_rst_b) |-> !o_scl_oe && !o_sda_oe && !o_irq)
    else $error("outputs active after reset");
  chk_ack_drive: assert property (w2 && i_apb.pwdata[5:3] == 3'h2 |->
    ##[1:4] (o_scl_oe && o_sda_oe)) else $error("ack not driven");
  chk_nack_free: assert property (w2 && i_apb.pwdata[5:3] == 3'h6 |=> !o_sda_oe [*6])
    else $error("nack drove sda");
  chk_stop_sda: assert property (w2 && i_apb.pwdata[4:2] == 3'h1 |-> ##[1:4] o_sda_oe)
    else $error("stop sda not low");
  // Reload of 3 in the bench makes a period four clocks
  chk_sda_after: assert property ($fell(o_scl_oe) && o_sda_oe |=> o_sda_oe [*2])
    else $error("sda freed with scl");
  chk_open_drain: assert property (!o_scl_out && !o_sda_out && !o_pslverr)
    else $error("drive value or error set");
endmodule : i2cm_master_monitor

bind i2cm_master i2cm_master_monitor mon_u (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
  .i_apb(i_apb), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_scl(i_scl), .i_sda(i_sda), .o_scl_oe(o_scl_oe), .o_sda_oe(o_sda_oe),
  .o_scl_out(o_scl_out), .o_sda_out(o_sda_out), .o_irq(o_irq));

/* File: bench/i2cm_slave_model.sv */
`timescale 1ns/1ps
// Far-side slave: returns a byte MSB first, can fight a released SDA
module i2cm_slave_model (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_b,
  input  wire logic       i_scl,
  input  wire logic       i_send,
  input  wire logic       i_clash,
  input  wire logic [7:0] i_byte,
  output logic            o_sda_oe
);
  logic       scl_q;
  logic       clocked;
  logic [3:0] idx;
  // Next bit after each falling SCL edge that follows a rise of this byte
  always_ff @(posedge i_clk_sys) begin
    scl_q <= i_scl;
    if (!i_rst_b || !i_send) begin
      idx     <= 4'h0;
      clocked <= 1'b0;
    end else begin
      if (!scl_q && i_scl) begin
        clocked <= 1'b1;
      end
      if (clocked && scl_q && !i_scl && idx < 4'h8) begin
        idx <= idx + 4'h1;
      end
    end
  end
  // Zeros pulled low; clash pulls SDA a clock into SCL high time
  assign o_sda_oe = (i_send && idx < 4'h8 && !i_byte[3'h7 - idx[2:0]])
                  || (i_clash && i_scl && scl_q);
endmodule : i2cm_slave_model

/* File: bench/tb.sv */
`timescale 1ns/1ps
module tb;
  import i2cm_pkg::*;
  logic          i_clk_sys = 1'b0;
  logic          i_rst_b   = 1'b0;
  i2cm_apb_req_s apb       = '0;
  logic          slv_send  = 1'b0;
  logic          slv_clash = 1'b0;
  logic [7:0]    slv_byte  = 8'h00;
  logic [31:0]   prdata;
  logic          pready, scl_oe, sda_oe, irq, slv_oe, scl, sda, scl_q, last_bit;
  int            errors, cmp_count, rises;

  i2cm_master dut_u (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_apb(apb), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(), .i_scl(scl), .i_sda(sda), .o_scl_oe(scl_oe),
    .o_sda_oe(sda_oe), .o_scl_out(), .o_sda_out(), .o_irq(irq));
  i2cm_slave_model slv_u (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_scl(scl),
    .i_send(slv_send), .i_clash(slv_clash), .i_byte(slv_byte), .o_sda_oe(slv_oe));

  // Wired-AND lines with pull-ups
  assign scl = ~scl_oe;
  assign sda = ~sda_oe & ~slv_oe;

  initial begin
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end

  // Count SCL rises and keep SDA seen at each
  always @(posedge i_clk_sys) begin
    scl_q <= scl;
    if (scl_q === 1'b0 && scl === 1'b1) begin
      rises <= rises + 1;
      last_bit <= sda;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One APB transfer, then one idle cycle
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge i_clk_sys);
    apb.penable <= 1'b1;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) errors++;
    q = prdata;
    apb <= '0;
    @(posedge i_clk_sys);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input string nm);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(nm, e, q & m);
  endtask : rchk

  // Wait until a request bit of the second control register clears
  task automatic poll(input int b);
    logic [31:0] q;
    int n;
    n = 0;
    q = '1;
    while (q[b] !== 1'b0 && n < 300) begin
      xfer(1'b0, I2CM_ADDR_CTRL2, 32'h0, q);
      n++;
    end
    chk("request bit", 32'h0, {31'h0, q[b]});
  endtask : poll

  task automatic rx(input logic [7:0] b, input logic mid);
    slv_byte <= b;
    slv_send <= 1'b1;
    rises = 0;
    wr(I2CM_ADDR_CTRL2, 32'h8);
    if (mid) begin
      wr(I2CM_ADDR_BUF, 32'h5A);
      wr(I2CM_ADDR_CTRL2, 32'h8);
    end
    poll(I2CM_C2_RECV);
    slv_send <= 1'b0;
    chk("scl rises", 32'h8, rises);
  endtask : rx

  task automatic t_reset();
    rchk(I2CM_ADDR_STATUS, 32'h19, 32'h0, "status");
    rchk(I2CM_ADDR_FLAGS, 32'hF, 32'h0, "flags");
    rchk(I2CM_ADDR_CTRL1, 32'h1, 32'h0, "enable");
    rchk(8'h1C, 32'hFFFFFFFF, 32'h0, "unmapped");
    wr(I2CM_ADDR_CTRL1, 32'h1);
    wr(I2CM_ADDR_RELOAD, 32'h103);
    rchk(I2CM_ADDR_RELOAD, 32'hFFFFFFFF, 32'h3, "reload");
  endtask : t_reset

  task automatic t_rx();
    rx(8'hA5, 1'b1);
    rchk(I2CM_ADDR_STATUS, 32'h1, 32'h1, "full");
    rchk(I2CM_ADDR_FLAGS, 32'h9, 32'h9, "sif write_collision_flag");
    chk("irq", 32'h1, {31'h0, irq});
    rchk(I2CM_ADDR_BUF, 32'hFF, 32'hA5, "buffer");
    rchk(I2CM_ADDR_STATUS, 32'h1, 32'h0, "full");
    wr(I2CM_ADDR_FLAGS, 32'hF);
  endtask : t_rx

  task automatic t_ovf();
    rx(8'h3C, 1'b0);
    rchk(I2CM_ADDR_FLAGS, 32'h4, 32'h0, "overflow");
    rx(8'hC3, 1'b0);
    rchk(I2CM_ADDR_FLAGS, 32'h4, 32'h4, "overflow");
    rchk(I2CM_ADDR_BUF, 32'hFF, 32'hC3, "buffer");
    wr(I2CM_ADDR_FLAGS, 32'hF);
  endtask : t_ovf

  task automatic t_ack(input logic dt);
    rises = 0;
    wr(I2CM_ADDR_CTRL2, {26'h0, dt, 5'h10});
    poll(I2CM_C2_ACKREQ);
    chk("ack clocks", 32'h1, rises);
    chk("ack bit", {31'h0, dt}, {31'h0, last_bit});
    chk("scl held", 32'h1, {31'h0, scl_oe});
  endtask : t_ack

  task automatic t_stop();
    wr(I2CM_ADDR_FLAGS, 32'hF);
    wr(I2CM_ADDR_CTRL2, 32'h4);
    poll(I2CM_C2_HALT);
    rchk(I2CM_ADDR_STATUS, 32'h10, 32'h10, "stop seen");
    rchk(I2CM_ADDR_FLAGS, 32'h1, 32'h1, "sif");
    chk("lines", 32'h3, {30'h0, scl, sda});
  endtask : t_stop

  task automatic t_clash();
    wr(I2CM_ADDR_FLAGS, 32'hF);
    wr(I2CM_ADDR_BUF, 32'h77);
    wr(I2CM_ADDR_CTRL2, 32'h30);
    slv_clash <= 1'b1;
    poll(I2CM_C2_ACKREQ);
    rchk(I2CM_ADDR_FLAGS, 32'h2, 32'h2, "collision");
    chk("released", 32'h0, {30'h0, scl_oe, sda_oe});
    chk("irq", 32'h1, {31'h0, irq});
    rchk(I2CM_ADDR_STATUS, 32'h1, 32'h0, "full dropped");
    slv_clash <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    rchk(I2CM_ADDR_FLAGS, 32'h1, 32'h1, "sif on stop");
    rchk(I2CM_ADDR_STATUS, 32'h18, 32'h10, "bus free");
    wr(I2CM_ADDR_BUF, 32'h66);
    rchk(I2CM_ADDR_BUF, 32'hFF, 32'h66, "buffer after collision");
  endtask : t_clash

  task automatic t_abort();
    wr(I2CM_ADDR_CTRL1, 32'h0);
    rchk(I2CM_ADDR_STATUS, 32'h18, 32'h0, "seen bits");
    wr(I2CM_ADDR_CTRL1, 32'h1);
    slv_send <= 1'b1;
    wr(I2CM_ADDR_CTRL2, 32'h8);
    repeat (10) @(posedge i_clk_sys);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    slv_send <= 1'b0;
    @(posedge i_clk_sys);
    chk("lines", 32'h0, {30'h0, scl_oe, sda_oe});
    rchk(I2CM_ADDR_CTRL2, 32'h8, 32'h0, "receive");
    rchk(I2CM_ADDR_CTRL1, 32'h1, 32'h0, "enable");
  endtask : t_abort

  task automatic conclude();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  initial begin
    errors = 0;
    cmp_count = 0;
    rises = 0;
    repeat (2) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    @(posedge i_clk_sys);
    t_reset();
    t_rx();
    t_ovf();
    t_ack(1'b0);
    t_ack(1'b1);
    t_stop();
    t_clash();
    t_abort();
    conclude();
  end

  // Hang guard
  initial begin
    #(25 * 30000);
    errors++;
    conclude();
  end
endmodule : tb
